/* File: include/pullup_pkg.sv */
// shared constants of the port pullup enable bank
package pullup_pkg;
    // bus widths
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;
    // four ports of eight pins each
    localparam int PORTS = 4;
    localparam int PINS = 8;
    localparam int PIN_TOTAL = PORTS * PINS;
    // register byte addresses, one per port
    localparam logic [ADDR_W-1:0] THIRD_PORT_PULL_ADDR = 16'h30F2;
    localparam logic [ADDR_W-1:0] FOURTH_PORT_PULL_ADDR = 16'h30F3;
    localparam logic [ADDR_W-1:0] FIFTH_PORT_PULL_ADDR = 16'h30F4;
    localparam logic [ADDR_W-1:0] SIXTH_PORT_PULL_ADDR = 16'h30F5;
    // port slots inside the bank
    localparam logic [1:0] THIRD_SLOT = 2'h0;
    localparam logic [1:0] FOURTH_SLOT = 2'h1;
    localparam logic [1:0] FIFTH_SLOT = 2'h2;
    localparam logic [1:0] SIXTH_SLOT = 2'h3;
    // reset value of every enable register
    localparam logic [DATA_W-1:0] PULL_RESET = 8'h00;
    // read value of an unmapped address
    localparam logic [DATA_W-1:0] UNMAPPED_READ = 8'h00;
    // decode result: valid flag and slot
    typedef struct packed {
        logic hit;
        logic [1:0] slot;
    } decode_t;
endpackage

/* File: include/pullup_cfg_if.sv */
// carrier between bus front end and the enable register file
`timescale 1ns/1ps
interface pullup_cfg_if;
    import pullup_pkg::*;
    // one write select per port, shared write data
    logic [PORTS-1:0] wr_sel;
    logic [PINS-1:0] wdata;
    // stored enables, slot-major
    logic [PORTS-1:0][PINS-1:0] en;
    // register file side
    modport store (input wr_sel, input wdata, output en);
    // bus front end side
    modport ctrl (output wr_sel, output wdata, input en);
endinterface

/* File: rtl/pullup_reg_file.sv */
// storage of the per-port pullup enable registers
`timescale 1ns/1ps
module pullup_reg_file (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // write port and stored values
    pullup_cfg_if.store cfg
);
    import pullup_pkg::*;

    // one byte per port, bit n steers pin n
    logic [PINS-1:0] mem_q [PORTS];

    // each slot loads only on its own select, cleared by reset
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < PORTS; i++) begin
                mem_q[i] <= PULL_RESET;
            end
        end else begin
            for (int i = 0; i < PORTS; i++) begin
                if (cfg.wr_sel[i]) begin
                    mem_q[i] <= cfg.wdata;
                end
            end
        end
    end

    // expose the stored bytes to the front end
    always_comb begin
        for (int i = 0; i < PORTS; i++) begin
            cfg.en[i] = mem_q[i];
        end
    end
endmodule

/* File: rtl/port_pullup_enable_bank.sv */
// pullup enable bank for four eight-pin general purpose ports
// Operation
// - set bit enables pullup of input pin
// - clear bit keeps pullup off
// - output or high-z pin ignores its bit
// - eight bits, bit n drives pin n
// - fourth port register at 30F3h
// - fifth port register at 30F4h, reset zero
// - sixth port register at 30F5h, reset zero
// - third port register at 30F2h, reset zero
//
// Our own choice: strobed register access.
`timescale 1ns/1ps
module port_pullup_enable_bank (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register port
    input wire logic [pullup_pkg::ADDR_W-1:0] addr,
    input wire logic [pullup_pkg::DATA_W-1:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [pullup_pkg::DATA_W-1:0] rdata,
    // pin configuration, slot-major: bit 8*p+n is pin n of port p
    input wire logic [pullup_pkg::PIN_TOTAL-1:0] pin_is_output,
    input wire logic [pullup_pkg::PIN_TOTAL-1:0] pin_is_hiz,
    // pad pullup enables, same bit order
    output logic [pullup_pkg::PIN_TOTAL-1:0] pad_pull_on
);
    import pullup_pkg::*;

    // carrier to the register file
    pullup_cfg_if cfg ();

    // stored enables flattened to pin order
    logic [PIN_TOTAL-1:0] en_flat;
    // read data register
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    // pad enable register
    logic [PIN_TOTAL-1:0] pull_on_q;
    logic [PIN_TOTAL-1:0] pull_on_d;
    // decode of the current address
    decode_t dec;

    // map an address onto a port slot; used for both writes and reads
    function automatic decode_t decode_addr(input logic [ADDR_W-1:0] a);
        decode_t r;
        r = '{hit: 1'b0, slot: THIRD_SLOT};
        case (a)
            THIRD_PORT_PULL_ADDR: begin
                r = '{hit: 1'b1, slot: THIRD_SLOT};
            end
            FOURTH_PORT_PULL_ADDR: begin
                r = '{hit: 1'b1, slot: FOURTH_SLOT};
            end
            FIFTH_PORT_PULL_ADDR: begin
                r = '{hit: 1'b1, slot: FIFTH_SLOT};
            end
            SIXTH_PORT_PULL_ADDR: begin
                r = '{hit: 1'b1, slot: SIXTH_SLOT};
            end
            default: begin
                // outside the bank: writes dropped, reads give zero
                r = '{hit: 1'b0, slot: THIRD_SLOT};
            end
        endcase
        return r;
    endfunction

    // the register file keeps the bytes themselves
    pullup_reg_file u_regs (
        .clk(clk),
        .rst(rst),
        .cfg(cfg)
    );

    // address decode shared by both strobes
    always_comb begin
        dec = decode_addr(addr);
    end

    // write select: one slot at most, only on a mapped address
    always_comb begin
        cfg.wdata = wdata;
        cfg.wr_sel = '0;
        if (wr && dec.hit) begin
            cfg.wr_sel[dec.slot] = 1'b1;
        end
    end

    // flatten stored bytes so bit 8*p+n is pin n of port p
    always_comb begin
        en_flat = cfg.en;
    end

    // read mux; unmapped or idle gives zero
    always_comb begin
        rdata_d = UNMAPPED_READ;
        if (rd && dec.hit) begin
            rdata_d = cfg.en[dec.slot];
        end
    end

    // read data stands only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q <= UNMAPPED_READ;
        end else begin
            // reading touches nothing but this register
            rdata_q <= rdata_d;
        end
    end

    // gate enables with pin direction; a driven or floating pin never
    // gets its pullup, so a stale enable cannot fight the output driver
    always_comb begin
        pull_on_d = en_flat & ~pin_is_output & ~pin_is_hiz;
    end

    // registered pad enables; one cycle latency is harmless for a pullup
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pull_on_q <= '0;
        end else begin
            pull_on_q <= pull_on_d;
        end
    end

    // outputs straight from flip-flops
    assign rdata = rdata_q;
    assign pad_pull_on = pull_on_q;

    // helper: low only in the first cycle after reset release
    logic seen_clk_q;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            seen_clk_q <= 1'b0;
        end else begin
            seen_clk_q <= 1'b1;
        end
    end

    // helper: direction of all eight sixth port pins for a slot-wide check
    logic [PINS-1:0] sixth_cfg_any;
    assign sixth_cfg_any = pin_is_output[PIN_TOTAL-1 -: PINS]
                           | pin_is_hiz[PIN_TOTAL-1 -: PINS];

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // an input pin with its bit set shows its pullup next cycle
    chk_pull_set_input: assert property (
        ##1 ((pad_pull_on & $past(en_flat & ~pin_is_output & ~pin_is_hiz))
            == $past(en_flat & ~pin_is_output & ~pin_is_hiz)))
        else $error("pullup missing on enabled input pin");

    // a cleared bit never yields a pullup
    chk_pull_clear_off: assert property (
        ##1 ((pad_pull_on & ~$past(en_flat)) == '0))
        else $error("pullup on while its enable bit is clear");

    // output or high-z pins never get a pullup
    chk_pull_dir_mask: assert property (
        ##1 ((pad_pull_on & $past(pin_is_output | pin_is_hiz)) == '0))
        else $error("pullup on for output or high-z pin");

    // a third port write lands in its own byte and leaves the sixth port byte alone
    chk_third_write_slot: assert property (
        (wr && addr == THIRD_PORT_PULL_ADDR)
        |=> (cfg.en[THIRD_SLOT] == $past(wdata))
            && $stable(cfg.en[SIXTH_SLOT]))
        else $error("third port write landed wrong");

    // fourth port write then read returns the byte
    chk_fourth_readback: assert property (
        (wr && addr == FOURTH_PORT_PULL_ADDR)
        ##1 (rd && addr == FOURTH_PORT_PULL_ADDR)
        |=> rdata == $past(wdata, 2))
        else $error("fourth port readback mismatch");

    // fifth port write reaches the pad two cycles later when pins are inputs
    chk_fifth_to_pad: assert property (
        (wr && addr == FIFTH_PORT_PULL_ADDR
            && pin_is_output[23:16] == '0 && pin_is_hiz[23:16] == '0)
        ##1 (pin_is_output[23:16] == '0 && pin_is_hiz[23:16] == '0)
        |=> pad_pull_on[23:16] == $past(wdata, 2))
        else $error("fifth port write did not reach pads");

    // sixth port write then read, no gap
    chk_sixth_readback: assert property (
        (wr && addr == SIXTH_PORT_PULL_ADDR)
        ##1 (rd && addr == SIXTH_PORT_PULL_ADDR)
        |=> rdata == $past(wdata, 2))
        else $error("sixth port readback mismatch");

    // all enables clear in the first cycle after reset
    chk_reset_clear: assert property (
        !seen_clk_q |-> (en_flat == '0 && pad_pull_on == '0 && rdata == '0))
        else $error("enables not cleared by reset");

    // a read leaves every enable register as it was
    chk_read_no_effect: assert property (
        (rd && !wr) |=> $stable(en_flat))
        else $error("read changed an enable register");

    // unmapped read answers zero and read data lasts one cycle
    chk_unmapped_zero: assert property (
        (!rd || !dec.hit) |=> rdata == UNMAPPED_READ)
        else $error("unmapped or idle read data not zero");

    // scenarios worth seeing
    cov_write_read: cover property (
        (wr && addr == FIFTH_PORT_PULL_ADDR) ##1 (rd && addr == FIFTH_PORT_PULL_ADDR));
    cov_masked_pin: cover property (
        |(en_flat & (pin_is_output | pin_is_hiz)));
    cov_all_pulled: cover property (pad_pull_on == {PIN_TOTAL{1'b1}});
    cov_sixth_masked: cover property (
        (cfg.en[SIXTH_SLOT] != '0) && (sixth_cfg_any != '0));
endmodule

/* File: bench/pad_pull_model.sv */
// model of the pad pullup devices that sit behind the enable bank
`timescale 1ns/1ps
module pad_pull_model (
    // clock
    input wire logic clk,
    // pullup enables from the bank
    input wire logic [31:0] pad_pull_on,
    // level seen at each pin
    output logic [31:0] pin_level
);
    // floating pins change every cycle, so a stale value never passes for a pull
    logic [31:0] wander_q = 32'h5555AAAA;
    // toggle the floating pattern on each rising clock edge
    always @(posedge clk) begin
        wander_q <= ~wander_q;
    end
    // a pin with its pullup on reads high, any other pin floats
    assign pin_level = pad_pull_on | (wander_q & ~pad_pull_on);
endmodule

/* File: bench/port_pullup_enable_bank_test.sv */
// self-checking bench for the port pullup enable bank
`timescale 1ns/1ps
module port_pullup_enable_bank_test;
    import pullup_pkg::*;
    // design stimulus and observation
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [DATA_W-1:0] rdata;
    logic [PIN_TOTAL-1:0] pin_is_output = '0;
    logic [PIN_TOTAL-1:0] pin_is_hiz = '0;
    logic [PIN_TOTAL-1:0] pad_pull_on;
    logic [31:0] pin_level;
    // verdict counters
    int n_fail = 0;
    int n_checks = 0;
    // expected read data, carried one edge to the data cycle
    logic [DATA_W-1:0] rd_exp = '0;
    logic [DATA_W-1:0] rd_exp_q = '0;
    logic rd_seen = 1'b0;
    // written values, third port in the low byte
    logic [31:0] regs_v = 32'hFF_A5_5A_81;
    // 50 MHz clock
    always #10 clk = ~clk;
    port_pullup_enable_bank dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .pin_is_output(pin_is_output), .pin_is_hiz(pin_is_hiz),
        .pad_pull_on(pad_pull_on));
    pad_pull_model pads (.clk(clk), .pad_pull_on(pad_pull_on), .pin_level(pin_level));
    // one comparison, reported at once on mismatch
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // one-cycle write, set right after an edge and taken at the next one
    task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
        wr <= 1'b1;
        rd <= 1'b0;
        addr <= a;
        wdata <= d;
        @(posedge clk);
    endtask
    // one-cycle read; the data cycle after it is checked by the monitor below
    task automatic rd_reg(input logic [15:0] a, input logic [7:0] exp);
        rd <= 1'b1;
        wr <= 1'b0;
        addr <= a;
        rd_exp <= exp;
        @(posedge clk);
    endtask
    // read data stands only in the cycle after its strobe, zero elsewhere;
    // looked at on the edge that ends that cycle, before the flops move
    always @(posedge clk) begin
        if (rd_seen) begin
            chk("rdata", {24'h0, rd_exp_q}, {24'h0, rdata});
        end else if (!rst) begin
            chk("rdata idle", 32'h0, {24'h0, rdata});
        end
        rd_seen <= rd;
        rd_exp_q <= rd_exp;
    end
    // bus idle; pads settle one edge after the last change, looked at one edge later
    task automatic pads_chk(input logic [31:0] exp);
        wr <= 1'b0;
        rd <= 1'b0;
        repeat (2) @(posedge clk);
        chk("pad_pull_on", exp, pad_pull_on);
        chk("pin_level", exp, pin_level & exp);
    endtask
    // print counts and verdict, then stop
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        repeat (5000) @(posedge clk);
        n_fail++;
        complete_run();
    end
    // main sequence
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        // all four registers clear out of reset, pads off
        for (int p = 0; p < 4; p++) begin
            rd_reg(THIRD_PORT_PULL_ADDR + 16'(p), 8'h00);
        end
        pads_chk(32'h0);
        // back to back writes of distinct patterns, one per port
        for (int p = 0; p < 4; p++) begin
            wr_reg(THIRD_PORT_PULL_ADDR + 16'(p), regs_v[8*p +: 8]);
        end
        // neighbouring unmapped bytes take no write and read zero
        wr_reg(16'h30F1, 8'hFF);
        wr_reg(16'h30F6, 8'hFF);
        rd_reg(16'h30F1, 8'h00);
        rd_reg(16'h30F6, 8'h00);
        // write then read with no gap, readback in the very next cycle
        for (int p = 0; p < 4; p++) begin
            wr_reg(THIRD_PORT_PULL_ADDR + 16'(p), regs_v[8*p +: 8]);
            rd_reg(THIRD_PORT_PULL_ADDR + 16'(p), regs_v[8*p +: 8]);
        end
        // every register read twice: last write, reads leave it alone
        for (int k = 0; k < 8; k++) begin
            rd_reg(THIRD_PORT_PULL_ADDR + 16'(k % 4), regs_v[8*(k%4) +: 8]);
        end
        // all pins inputs: each set bit turns on its own pin
        pads_chk(regs_v);
        // outputs and high-z pins drop their pullups
        pin_is_output <= 32'h0000_00F0;
        pin_is_hiz <= 32'h0F00_0001;
        pads_chk(regs_v & ~32'h0F00_00F1);
        // back to inputs; a walking bit in the fourth port reaches pin n only
        pin_is_output <= '0;
        pin_is_hiz <= '0;
        for (int n = 0; n < 8; n++) begin
            wr_reg(FOURTH_PORT_PULL_ADDR, 8'h01 << n);
            pads_chk({regs_v[31:16], 8'h01 << n, regs_v[7:0]});
        end
        // clearing a register turns its pullups off again
        wr_reg(SIXTH_PORT_PULL_ADDR, 8'h00);
        rd_reg(SIXTH_PORT_PULL_ADDR, 8'h00);
        pads_chk({8'h00, regs_v[23:16], 8'h80, regs_v[7:0]});
        complete_run();
    end
endmodule
